//--- inc/two_wire_pkg.sv
// shared constants and carrier types of the two-wire status block
package two_wire_pkg;

    // ==========================================
    // register map (word aligned byte offsets)
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_STATUS = 8'h00;
    localparam logic [7:0] OFF_CONTROL = 8'h04;
    localparam logic [7:0] OFF_TX = 8'h08;
    localparam logic [7:0] OFF_RX = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h18;

    // ==========================================
    // field positions and reset values
    localparam int BIT_ON = 15;
    localparam int BIT_WCOL = 7;
    localparam int BIT_OVF = 6;
    localparam int BIT_STOP = 4;
    localparam int BIT_START = 3;
    localparam int LANE_LOW = 0;
    localparam int LANE_ON = 1;
    localparam int BYTE_W = 8;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ==========================================
    // interrupt sources
    localparam int IRQ_N = 5;
    localparam int IRQ_COLLISION = 0;
    localparam int IRQ_WCOL = 1;
    localparam int IRQ_OVF = 2;
    localparam int IRQ_STOP = 3;
    localparam int IRQ_RXFULL = 4;
    localparam logic [IRQ_N-1:0] IRQ_RESET = 5'h00;

    // ==========================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ==========================================
    // carriers
    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } regWr_t;

    // events from the shift engine, all same-clock one-cycle pulses except busy and rwBit
    typedef struct packed {
        logic masterTxStart;
        logic ackDone;
        logic ackNack;
        logic collision;
        logic generalCallMatch;
        logic tenBitMatch;
        logic addrMatch;
        logic rwBit;
        logic dataRx;
        logic rxReady;
        logic startDet;
        logic stopDet;
        logic txTaken;
        logic busy;
    } engineEvt_t;

    typedef struct packed {
        logic [15:0] rsvdHigh;
        logic ackResult;
        logic txInProgress;
        logic [2:0] rsvdMid;
        logic busCollision;
        logic generalCall;
        logic tenBitMatch;
        logic writeCollision;
        logic rxOverflow;
        logic dataNotAddr;
        logic stopSeen;
        logic startSeen;
        logic readNotWrite;
        logic rxFull;
        logic txFull;
    } status_t;

endpackage : two_wire_pkg

//--- logic/flag_cell.sv
// sticky flag bit where a set wins over a clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module flag_cell (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // set and clear
    input wire logic setEv,
    input wire logic clrEv,
    // flag
    output logic flag_q
);
    // set wins so no event is lost at a clear
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            flag_q <= 1'b0;
        end else if (setEv) begin
            flag_q <= 1'b1;
        end else if (clrEv) begin
            flag_q <= 1'b0;
        end
    end
endmodule : flag_cell
`default_nettype wire

//--- logic/axi_lite_slave.sv
// axi4-lite slave front end giving a write pulse and a read strobe
`timescale 1ns/1ps
`default_nettype none
module axi_lite_slave (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // write address and data
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address and data
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // register side
    output two_wire_pkg::regWr_t regWr,
    input wire logic wrHit,
    output logic rdStrobe,
    output logic [7:0] rdAddr,
    input wire logic [31:0] rdWord,
    input wire logic rdHit
);
    logic awHeld_q;
    logic wHeld_q;
    logic [7:0] addr_q;
    logic [31:0] data_q;
    logic [3:0] strb_q;
    logic doWrite;

    // channel readies and the write pulse once both halves are held
    assign awready = !awHeld_q;
    assign wready = !wHeld_q;
    assign doWrite = awHeld_q && wHeld_q && !bvalid;
    assign regWr = '{en: doWrite, addr: addr_q, data: data_q, strb: strb_q};
    assign arready = !rvalid;
    assign rdStrobe = arvalid && arready;
    assign rdAddr = araddr;

    // write address holding
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            awHeld_q <= 1'b0;
            addr_q <= two_wire_pkg::BYTE_RESET;
        end else if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            addr_q <= awaddr;
        end else if (doWrite) begin
            awHeld_q <= 1'b0;
        end
    end

    // write data holding
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wHeld_q <= 1'b0;
            data_q <= two_wire_pkg::WORD_ZERO;
            strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            data_q <= wdata;
            strb_q <= wstrb;
        end else if (doWrite) begin
            wHeld_q <= 1'b0;
        end
    end

    // write response
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= two_wire_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // read answer one cycle after the address is taken
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= two_wire_pkg::WORD_ZERO;
            rresp <= two_wire_pkg::RESP_OKAY;
        end else if (rdStrobe) begin
            rvalid <= 1'b1;
            rdata <= rdHit ? rdWord : two_wire_pkg::WORD_ZERO;
            rresp <= rdHit ? two_wire_pkg::RESP_OKAY : two_wire_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : axi_lite_slave
`default_nettype wire

//--- logic/two_wire_status_flags.sv
// status flags, holding registers and interrupt of a two-wire controller
//
// Operation
// - ack result flag: one means slave did not acknowledge
// - tx in progress from start to ack end
// - bus collision sticky until module re-enabled
// - general call flag set on match, stop clears
// - ten-bit flag set on second byte match
// - tx write while busy discarded, write collision
// - receive while holding full sets overflow flag
// - data/address: address match clears, data sets
// - unused status bits always read zero
// - flags zero at reset; some software clearable
//
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module two_wire_status_flags (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // axi4-lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // shift engine side
    input wire two_wire_pkg::engineEvt_t evt,
    input wire logic [7:0] rxShiftByte,
    output logic moduleOn,
    output logic [7:0] txByte,
    output logic txPending,
    // interrupt
    output logic irq
);
    // ==========================================
    // register bus
    two_wire_pkg::regWr_t regWr;
    two_wire_pkg::status_t statusWord;
    logic wrHit;
    logic rdStrobe;
    logic [7:0] rdAddr;
    logic [31:0] rdWord;
    logic rdHit;

    axi_lite_slave u_bus (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .regWr(regWr),
        .wrHit(wrHit),
        .rdStrobe(rdStrobe),
        .rdAddr(rdAddr),
        .rdWord(rdWord),
        .rdHit(rdHit)
    );

    // decoded write strobes and the rx read strobe
    logic lowLane;
    logic statusWr;
    logic controlWr;
    logic txWr;
    logic irqClearWr;
    logic irqEnableWr;
    logic rxRead;
    assign lowLane = regWr.strb[two_wire_pkg::LANE_LOW];
    assign statusWr = regWr.en && regWr.addr == two_wire_pkg::OFF_STATUS && lowLane;
    assign controlWr = regWr.en && regWr.addr == two_wire_pkg::OFF_CONTROL
        && regWr.strb[two_wire_pkg::LANE_ON];
    assign txWr = regWr.en && regWr.addr == two_wire_pkg::OFF_TX && lowLane;
    assign irqClearWr = regWr.en && regWr.addr == two_wire_pkg::OFF_IRQ_CLEAR && lowLane;
    assign irqEnableWr = regWr.en && regWr.addr == two_wire_pkg::OFF_IRQ_ENABLE && lowLane;
    assign rxRead = rdStrobe && rdAddr == two_wire_pkg::OFF_RX;

    // ==========================================
    // control
    logic moduleOn_q;
    logic enableRise;
    assign enableRise = controlWr && regWr.data[two_wire_pkg::BIT_ON] && !moduleOn_q;
    assign moduleOn = moduleOn_q;

    // module on bit
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            moduleOn_q <= 1'b0;
        end else if (controlWr) begin
            moduleOn_q <= regWr.data[two_wire_pkg::BIT_ON];
        end
    end

    // ==========================================
    // master transmit flags
    logic ackResultFlag_q;
    logic txInProgressFlag_q;
    logic busCollisionFlag_q;
    logic bclSet;
    assign bclSet = evt.collision && moduleOn_q && !busCollisionFlag_q;

    // acknowledge result taken at end of slave acknowledge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            ackResultFlag_q <= 1'b0;
        end else if (evt.ackDone) begin
            ackResultFlag_q <= evt.ackNack;
        end
    end

    // transmit in progress across eight bits plus acknowledge
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            txInProgressFlag_q <= 1'b0;
        end else if (evt.masterTxStart) begin
            txInProgressFlag_q <= 1'b1;
        end else if (evt.ackDone) begin
            txInProgressFlag_q <= 1'b0;
        end
    end

    // collision stays until the module is switched back on
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            busCollisionFlag_q <= 1'b0;
        end else if (enableRise) begin
            busCollisionFlag_q <= 1'b0;
        end else if (bclSet) begin
            busCollisionFlag_q <= 1'b1;
        end
    end

    // ==========================================
    // slave address flags
    logic generalCallFlag_q;
    logic tenBitMatchFlag_q;
    logic dataNotAddrFlag_q;
    logic readNotWrite_q;

    // general call and ten-bit match, both dropped at stop
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            generalCallFlag_q <= 1'b0;
            tenBitMatchFlag_q <= 1'b0;
        end else begin
            if (evt.generalCallMatch) begin
                generalCallFlag_q <= 1'b1;
            end else if (evt.stopDet) begin
                generalCallFlag_q <= 1'b0;
            end
            if (evt.tenBitMatch) begin
                tenBitMatchFlag_q <= 1'b1;
            end else if (evt.stopDet) begin
                tenBitMatchFlag_q <= 1'b0;
            end
        end
    end

    // last byte kind and direction of the address
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            dataNotAddrFlag_q <= 1'b0;
            readNotWrite_q <= 1'b0;
        end else if (evt.addrMatch) begin
            dataNotAddrFlag_q <= 1'b0;
            readNotWrite_q <= evt.rwBit;
        end else if (evt.dataRx) begin
            dataNotAddrFlag_q <= 1'b1;
        end
    end

    // ==========================================
    // software clearable flags
    logic writeCollisionFlag_q;
    logic rxOverflowFlag_q;
    logic stopFlag_q;
    logic startFlag_q;
    logic wcolSet;
    logic ovfSet;
    logic rxFullFlag_q;
    assign wcolSet = txWr && evt.busy;
    assign ovfSet = evt.rxReady && rxFullFlag_q;

    flag_cell u_wcol (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setEv(wcolSet),
        .clrEv(statusWr && !regWr.data[two_wire_pkg::BIT_WCOL]),
        .flag_q(writeCollisionFlag_q)
    );
    flag_cell u_ovf (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setEv(ovfSet),
        .clrEv(statusWr && !regWr.data[two_wire_pkg::BIT_OVF]),
        .flag_q(rxOverflowFlag_q)
    );
    flag_cell u_stop (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setEv(evt.stopDet),
        .clrEv(evt.startDet || (statusWr && !regWr.data[two_wire_pkg::BIT_STOP])),
        .flag_q(stopFlag_q)
    );
    flag_cell u_start (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .setEv(evt.startDet),
        .clrEv(evt.stopDet || (statusWr && !regWr.data[two_wire_pkg::BIT_START])),
        .flag_q(startFlag_q)
    );

    // ==========================================
    // holding registers
    logic [7:0] rxHolding_q;
    logic [7:0] txHolding_q;
    logic txFullFlag_q;
    logic rxLoad;
    assign rxLoad = evt.rxReady && !rxFullFlag_q;
    assign txByte = txHolding_q;
    assign txPending = txFullFlag_q;

    // receive side, an overflowing byte is dropped
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rxHolding_q <= two_wire_pkg::BYTE_RESET;
            rxFullFlag_q <= 1'b0;
        end else if (rxLoad) begin
            rxHolding_q <= rxShiftByte;
            rxFullFlag_q <= 1'b1;
        end else if (rxRead) begin
            rxFullFlag_q <= 1'b0;
        end
    end

    // transmit side, busy writes never land
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            txHolding_q <= two_wire_pkg::BYTE_RESET;
            txFullFlag_q <= 1'b0;
        end else if (txWr && !evt.busy) begin
            txHolding_q <= regWr.data[two_wire_pkg::BYTE_W-1:0];
            txFullFlag_q <= 1'b1;
        end else if (evt.txTaken) begin
            txFullFlag_q <= 1'b0;
        end
    end

    // ==========================================
    // interrupt status, clear and enable
    logic [two_wire_pkg::IRQ_N-1:0] irqEvents;
    logic [two_wire_pkg::IRQ_N-1:0] irqStatus;
    logic [two_wire_pkg::IRQ_N-1:0] irqEnable_q;
    assign irqEvents = {rxLoad, evt.stopDet, ovfSet, wcolSet, bclSet};

    // one sticky cell per source
    for (genvar i = 0; i < two_wire_pkg::IRQ_N; i++) begin : g_irq
        flag_cell u_cell (
            .core_clk(core_clk),
            .rst_b(rst_b),
            .setEv(irqEvents[i]),
            .clrEv(irqClearWr && regWr.data[i]),
            .flag_q(irqStatus[i])
        );
    end

    // enable mask
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irqEnable_q <= two_wire_pkg::IRQ_RESET;
        end else if (irqEnableWr) begin
            irqEnable_q <= regWr.data[two_wire_pkg::IRQ_N-1:0];
        end
    end
    assign irq = |(irqStatus & irqEnable_q);

    // ==========================================
    // read mux
    always_comb begin
        statusWord = '0;
        statusWord.ackResult = ackResultFlag_q;
        statusWord.txInProgress = txInProgressFlag_q;
        statusWord.busCollision = busCollisionFlag_q;
        statusWord.generalCall = generalCallFlag_q;
        statusWord.tenBitMatch = tenBitMatchFlag_q;
        statusWord.writeCollision = writeCollisionFlag_q;
        statusWord.rxOverflow = rxOverflowFlag_q;
        statusWord.dataNotAddr = dataNotAddrFlag_q;
        statusWord.stopSeen = stopFlag_q;
        statusWord.startSeen = startFlag_q;
        statusWord.readNotWrite = readNotWrite_q;
        statusWord.rxFull = rxFullFlag_q;
        statusWord.txFull = txFullFlag_q;
    end

    // read data and decode hit
    always_comb begin
        rdWord = two_wire_pkg::WORD_ZERO;
        rdHit = 1'b1;
        unique case (rdAddr)
            two_wire_pkg::OFF_STATUS: rdWord = statusWord;
            two_wire_pkg::OFF_CONTROL: rdWord[two_wire_pkg::BIT_ON] = moduleOn_q;
            two_wire_pkg::OFF_RX: rdWord[two_wire_pkg::BYTE_W-1:0] = rxHolding_q;
            two_wire_pkg::OFF_IRQ_STATUS: rdWord[two_wire_pkg::IRQ_N-1:0] = irqStatus;
            two_wire_pkg::OFF_IRQ_ENABLE: rdWord[two_wire_pkg::IRQ_N-1:0] = irqEnable_q;
            two_wire_pkg::OFF_TX, two_wire_pkg::OFF_IRQ_CLEAR: rdWord = two_wire_pkg::WORD_ZERO;
            default: rdHit = 1'b0;
        endcase
    end
    assign wrHit = regWr.addr == two_wire_pkg::OFF_STATUS
        || regWr.addr == two_wire_pkg::OFF_CONTROL || regWr.addr == two_wire_pkg::OFF_TX
        || regWr.addr == two_wire_pkg::OFF_RX || regWr.addr == two_wire_pkg::OFF_IRQ_STATUS
        || regWr.addr == two_wire_pkg::OFF_IRQ_CLEAR || regWr.addr == two_wire_pkg::OFF_IRQ_ENABLE;

    // ==========================================
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_ACK_RESULT: assert property (
        evt.ackDone |=> statusWord.ackResult == $past(evt.ackNack))
        else $error("ack result flag does not follow acknowledge");
    AST_TX_PROGRESS: assert property (
        evt.masterTxStart ##1 !evt.ackDone[*2] |-> statusWord.txInProgress)
        else $error("transmit in progress dropped early");
    AST_TX_END: assert property (
        evt.ackDone && !evt.masterTxStart |=> !statusWord.txInProgress)
        else $error("transmit in progress not cleared at acknowledge end");
    AST_BCL_STICKY: assert property (
        statusWord.busCollision && !enableRise |=> statusWord.busCollision)
        else $error("bus collision cleared without re-enable");
    AST_GC_STOP: assert property (
        evt.stopDet && !evt.generalCallMatch |=> !statusWord.generalCall)
        else $error("general call not cleared at stop");
    AST_TEN_BIT: assert property (
        evt.tenBitMatch |=> statusWord.tenBitMatch)
        else $error("ten-bit match not flagged");
    AST_WCOL: assert property (
        txWr && evt.busy |=> statusWord.writeCollision && $stable(txHolding_q))
        else $error("busy write not discarded with collision");
    AST_OVF: assert property (
        evt.rxReady && rxFullFlag_q |=> statusWord.rxOverflow && $stable(rxHolding_q))
        else $error("overflow not flagged or byte overwritten");
    AST_DATA_ADDR: assert property (
        (evt.addrMatch |=> !statusWord.dataNotAddr)
        and (evt.dataRx && !evt.addrMatch |=> statusWord.dataNotAddr))
        else $error("data/address flag wrong after address or data");
    AST_RESERVED: assert property (
        rvalid && rresp == two_wire_pkg::RESP_OKAY && $past(rdStrobe)
        && $past(rdAddr) == two_wire_pkg::OFF_STATUS |-> rdata[31:16] == 16'h0000
        && rdata[13:11] == 3'h0)
        else $error("reserved status bits read nonzero");
    AST_RESET_ZERO: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_b |=> statusWord == two_wire_pkg::WORD_ZERO)
        else $error("status not zero after reset");
    AST_START_STOP: assert property (
        evt.stopDet && !evt.startDet |=> statusWord.stopSeen && !statusWord.startSeen)
        else $error("stop did not set stop and clear start");
    AST_RX_FULL: assert property (
        rxLoad |=> statusWord.rxFull && rxHolding_q == $past(rxShiftByte))
        else $error("receive holding not loaded");
endmodule : two_wire_status_flags
`default_nettype wire

//--- test/engine_model.sv
// far-side engine model replaying bus events asked for by the bench
`timescale 1ns/1ps
`default_nettype none
module engine_model (
    // clock
    input wire logic core_clk,
    // requests from bench
    input wire logic [13:0] evtReq,
    input wire logic [7:0] byteReq,
    // engine events
    output two_wire_pkg::engineEvt_t evt,
    output logic [7:0] rxShiftByte
);
    // events one edge after the request; byte only meaningful with rxReady
    always_ff @(posedge core_clk) begin
        evt <= two_wire_pkg::engineEvt_t'(evtReq);
        rxShiftByte <= evtReq[4] ? byteReq : ~rxShiftByte;
    end
endmodule : engine_model
`default_nettype wire

//--- test/tb_two_wire_status_flags.sv
// self-checking bench for the two-wire status flag block
`timescale 1ns/1ps
`default_nettype none
module tb_two_wire_status_flags;
    logic core_clk = 0, rst_b = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, txByte, byteReq = 0, rxShiftByte;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, moduleOn, txPending, irq, busy = 0;
    logic [13:0] evtReq = 0;
    two_wire_pkg::engineEvt_t evt;
    int mismatches = 0, checked = 0, cycles = 0;
    two_wire_status_flags i_dut (.core_clk(core_clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .evt(evt), .rxShiftByte(rxShiftByte), .moduleOn(moduleOn),
        .txByte(txByte), .txPending(txPending), .irq(irq));
    engine_model i_eng (.core_clk(core_clk), .evtReq(evtReq), .byteReq(byteReq), .evt(evt),
        .rxShiftByte(rxShiftByte));
    // 40 MHz clock and hang guard
    always #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // ==========================================
    // register bus master: sample at negedge, act at posedge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge core_clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid;
            @(posedge core_clk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end while (b !== 1'b1);
        bready <= 0;
        @(posedge core_clk);
    endtask : wr
    task automatic rdw(input logic [7:0] a);
        logic ar, r;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge core_clk);
            ar = arvalid & arready;
            r = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge core_clk);
            if (ar) arvalid <= 0;
        end while (r !== 1'b1);
        rready <= 0;
        @(posedge core_clk);
    endtask : rdw
    // one-cycle engine event, busy level kept underneath
    task automatic ev(input logic [13:0] bits, input logic [7:0] by);
        evtReq <= bits | {13'h0, busy};
        byteReq <= by;
        @(posedge core_clk);
        evtReq <= {13'h0, busy};
        repeat (2) @(posedge core_clk);
    endtask : ev
    task automatic st(input logic [31:0] exp);
        rdw(8'h00);
        chk("status", rd, exp);
    endtask : st
    // ==========================================
    // tests
    initial begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1;
        @(posedge core_clk);
        st(32'h0000_0000);
        wr(8'h04, 32'h0000_8000);
        chk("moduleOn", moduleOn, 1);
        wr(8'h18, 32'h0000_001F);
        ev(14'h2000, 8'h00);
        st(32'h0000_4000);
        ev(14'h1800, 8'h00);
        st(32'h0000_8000);
        $display("test master transmit done");
        ev(14'h0400, 8'h00);
        wr(8'h00, 32'h0000_0000);
        st(32'h0000_8400);
        chk("irq", irq, 1);
        wr(8'h14, 32'h0000_001F);
        chk("irq", irq, 0);
        ev(14'h0308, 8'h00);
        st(32'h0000_8708);
        ev(14'h0004, 8'h00);
        st(32'h0000_8410);
        $display("test collision and calls done");
        busy = 1;
        ev(14'h0000, 8'h00);
        wr(8'h08, 32'h0000_005A);
        chk("txPending", txPending, 0);
        busy = 0;
        ev(14'h0000, 8'h00);
        wr(8'h08, 32'h0000_00A5);
        chk("txByte", {txPending, txByte}, 9'h1A5);
        st(32'h0000_8491);
        ev(14'h0002, 8'h00);
        ev(14'h0010, 8'h3C);
        ev(14'h0010, 8'h99);
        st(32'h0000_84D2);
        rdw(8'h0C);
        chk("rx", rd, 32'h0000_003C);
        $display("test holding registers done");
        ev(14'h0080, 8'h00);
        ev(14'h0020, 8'h00);
        st(32'h0000_84F0);
        ev(14'h00C0, 8'h00);
        st(32'h0000_84D4);
        wr(8'h00, 32'h0000_0000);
        st(32'h0000_8404);
        wr(8'h04, 32'h0000_0000);
        chk("moduleOn", moduleOn, 0);
        wr(8'h04, 32'h0000_8000);
        st(32'h0000_8004);
        ev(14'h1000, 8'h00);
        st(32'h0000_0004);
        rdw(8'h40);
        chk("unmapped rresp", rs, two_wire_pkg::RESP_SLVERR);
        chk("unmapped rdata", rd, 32'h0000_0000);
        wr(8'h40, 32'h0000_0000);
        chk("unmapped bresp", bresp, two_wire_pkg::RESP_SLVERR);
        $display("test software clears done");
        give_verdict();
    end
endmodule : tb_two_wire_status_flags
`default_nettype wire
